// ===== logic/rsw_auto_pick.v
// Priority-based pick of the best valid reference input.
`timescale 1ns/1ns
`default_nettype none
module rsw_auto_pick (
    input wire [7:0] ranks,
    input wire [3:0] valid,
    output reg found,
    output reg [1:0] pick,
    output reg [1:0] pick_rank
);
    integer i;

    // Scan from input 3 down to 0 with >=, so a lower index wins ties.
    always @* begin
        found = 1'b0;
        pick = 2'h0;
        pick_rank = 2'h0;
        for (i = 3; i >= 0; i = i - 1) begin
            if (valid[i] && (ranks[7-2*i -: 2] != 2'h0) &&
                (!found || ranks[7-2*i -: 2] >= pick_rank)) begin
                found = 1'b1;
                pick = i[1:0];
                pick_rank = ranks[7-2*i -: 2];
            end
        end
    end
endmodule // rsw_auto_pick
`default_nettype wire

// ===== logic/rsw_regs.vh
// Register offsets, field positions, reset values and codes for the reference switch control.
`ifndef RSW_REGS_VH
`define RSW_REGS_VH
// ****************************************************************
// Register byte addresses on the APB bus
// ****************************************************************
`define RSW_ADDR_W 8
`define RSW_OFF_INPUT_PRIORITY_RANKS 8'h34
`define RSW_OFF_REFERENCE_SWITCH_CONTROL 8'h35
`define RSW_OFF_HOLDOFF_COUNT_PERIOD 8'h36
`define RSW_OFF_HOLDOFF_DIVIDER_CONTROL 8'h37
`define RSW_OFF_STATUS 8'h38
// ****************************************************************
// Field positions and masks
// ****************************************************************
`define RSW_CTL_MASK_BIT 6
`define RSW_CTL_REVERTIVE_SWITCH_ENABLE_BIT 5
`define RSW_CTL_POLICY_LSB 2
`define RSW_CTL_SEL_LSB 0
`define RSW_CTL_WMASK 8'h6f
`define RSW_HDC_WMASK 8'hc3
// ****************************************************************
// Reset values
// ****************************************************************
`define RSW_RST_RANKS 8'he4
`define RSW_RST_CTL 8'h00
`define RSW_RST_HOLDOFF_PERIOD 8'h80
`define RSW_RST_HDC 8'h00
// ****************************************************************
// Selection policy codes
// ****************************************************************
`define RSW_POL_MANUAL 2'h0
`define RSW_POL_AUTO 2'h1
`define RSW_POL_SHORT_HOLD 2'h2
`define RSW_POL_AUTO_HOLD 2'h3
`endif

// ===== logic/rsw_reset_sync.v
// Reset synchroniser: asynchronous assert, release through two flip-flops.
`timescale 1ns/1ns
`default_nettype none
module rsw_reset_sync (
    input wire clock,
    input wire rst_b,
    output wire rst_sync_b
);
    reg meta_q;
    reg sync_q;

    // The first stage loads a constant, the second copies the first; release is delayed by two edges.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign rst_sync_b = sync_q;
endmodule // rsw_reset_sync
`default_nettype wire

// ===== logic/rsw_switch_ctrl.v
// Reference input switch control: registers, selection policy and lock status masking.
`timescale 1ns/1ns
`default_nettype none
`include "rsw_regs.vh"
module rsw_switch_ctrl (
    input wire clock,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [3:0] ref_valid,
    input wire pll_lock_lost,
    output reg [1:0] ref_select,
    output reg ref_select_valid,
    output reg lock_state_live,
    output reg lock_state_latched,
    output reg gpio_ref_loss,
    output reg [7:0] holdoff_period,
    output reg [1:0] holdoff_prescale,
    output reg [1:0] holdoff_aux_field
);
    // ****************************************************************
    // Reset and bus decode
    // ****************************************************************
    wire rst_sync_b;
    reg [7:0] ranks_q;
    reg [7:0] ctl_q;
    reg [7:0] hdc_q;
    reg [1:0] auto_sel_q;
    reg auto_has_q;
    reg [3:0] valid_prev_q;

    rsw_reset_sync u_rst (
        .clock(clock),
        .rst_b(rst_b),
        .rst_sync_b(rst_sync_b)
    );

    // Decodes an address into a one-hot register select, used by read and write.
    function [4:0] reg_hit;
        input [31:0] addr;
        begin
            reg_hit = 5'h00;
            if (addr[31:8] == 24'h000000) begin
                case (addr[7:0])
                    `RSW_OFF_INPUT_PRIORITY_RANKS: reg_hit = 5'h01;
                    `RSW_OFF_REFERENCE_SWITCH_CONTROL: reg_hit = 5'h02;
                    `RSW_OFF_HOLDOFF_COUNT_PERIOD: reg_hit = 5'h04;
                    `RSW_OFF_HOLDOFF_DIVIDER_CONTROL: reg_hit = 5'h08;
                    `RSW_OFF_STATUS: reg_hit = 5'h10;
                    default: reg_hit = 5'h00;
                endcase
            end
        end
    endfunction

    // The slave answers in the first access cycle; no wait states are ever inserted.
    assign pready = 1'b1;
    wire [4:0] hit = reg_hit(paddr);
    wire access = psel && penable;
    wire wr_en = access && pwrite;
    // Unmapped addresses answer with an error rather than silently vanishing.
    assign pslverr = access && (hit == 5'h00);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    wire [1:0] policy = ctl_q[`RSW_CTL_POLICY_LSB +: 2];
    wire [1:0] man_sel = ctl_q[`RSW_CTL_SEL_LSB +: 2];
    wire mask_on = ctl_q[`RSW_CTL_MASK_BIT];
    wire revertive_switch_enable_on = ctl_q[`RSW_CTL_REVERTIVE_SWITCH_ENABLE_BIT];
    wire is_auto = policy[0];

    // Reserved positions are masked off on write so they read back as zero.
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ranks_q <= `RSW_RST_RANKS;
            ctl_q <= `RSW_RST_CTL;
            holdoff_period <= `RSW_RST_HOLDOFF_PERIOD;
            hdc_q <= `RSW_RST_HDC;
        end else if (wr_en) begin
            if (hit[0]) begin
                ranks_q <= pwdata[7:0];
            end
            if (hit[1]) begin
                ctl_q <= pwdata[7:0] & `RSW_CTL_WMASK;
            end
            if (hit[2]) begin
                holdoff_period <= pwdata[7:0];
            end
            if (hit[3]) begin
                hdc_q <= pwdata[7:0] & `RSW_HDC_WMASK;
            end
        end
    end

    // Holdoff fields are only held here; the counter that uses them lives elsewhere.
    always @* begin
        holdoff_prescale = hdc_q[7:6];
        holdoff_aux_field = hdc_q[1:0];
    end

    // ****************************************************************
    // Automatic selection
    // ****************************************************************
    wire best_found;
    wire [1:0] best_pick;
    wire [1:0] best_rank;

    rsw_auto_pick u_pick (
        .ranks(ranks_q),
        .valid(ref_valid),
        .found(best_found),
        .pick(best_pick),
        .pick_rank(best_rank)
    );

    // Rank of an input, taken from the packed rank byte (input 0 in the top bits).
    function [1:0] rank_of;
        input [7:0] r;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: rank_of = r[7:6];
                2'h1: rank_of = r[5:4];
                2'h2: rank_of = r[3:2];
                default: rank_of = r[1:0];
            endcase
        end
    endfunction

    wire [3:0] revalid = ref_valid & ~valid_prev_q;
    wire [3:0] nonsel_revalid = revalid & ~(4'h1 << auto_sel_q);
    wire cur_ok = auto_has_q && ref_valid[auto_sel_q] &&
        (rank_of(ranks_q, auto_sel_q) != 2'h0);
    wire outranks = best_found && (best_rank > rank_of(ranks_q, auto_sel_q));

    // A failed or unset choice is replaced at once; a healthy one only moves on
    // revertive re-validation, and then only upward. This avoids needless hops.
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            auto_sel_q <= 2'h0;
            auto_has_q <= 1'b0;
            valid_prev_q <= 4'h0;
        end else begin
            valid_prev_q <= ref_valid;
            if (!is_auto) begin
                auto_has_q <= 1'b0;
            end else if (!cur_ok) begin
                auto_has_q <= best_found;
                if (best_found) begin
                    auto_sel_q <= best_pick;
                end
            end else if (revertive_switch_enable_on && (nonsel_revalid != 4'h0) && outranks) begin
                auto_sel_q <= best_pick;
            end
            // Without revertive enable a re-validated input changes nothing.
        end
    end

    // ****************************************************************
    // Outputs: selection, lock status, GPIO loss report
    // ****************************************************************
    wire [1:0] sel_d = is_auto ? auto_sel_q : man_sel;
    wire sel_valid_d = is_auto ? auto_has_q : 1'b1;
    wire ref_lost = !ref_valid[sel_d] || !sel_valid_d;
    wire lock_fail = pll_lock_lost || (!mask_on && ref_lost);

    // Latched status holds until software writes a one to it in the status word.
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ref_select <= 2'h0;
            ref_select_valid <= 1'b0;
            lock_state_live <= 1'b0;
            lock_state_latched <= 1'b0;
            gpio_ref_loss <= 1'b0;
        end else begin
            ref_select <= sel_d;
            ref_select_valid <= sel_valid_d;
            lock_state_live <= lock_fail;
            gpio_ref_loss <= ref_lost && !mask_on;
            if (lock_fail) begin
                lock_state_latched <= 1'b1;
            end else if (wr_en && hit[4] && pwdata[1]) begin
                lock_state_latched <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always @* begin
        prdata = 32'h00000000;
        if (access && !pwrite) begin
            case (hit)
                5'h01: prdata = {24'h000000, ranks_q};
                5'h02: prdata = {24'h000000, ctl_q};
                5'h04: prdata = {24'h000000, holdoff_period};
                5'h08: prdata = {24'h000000, hdc_q};
                5'h10: prdata = {24'h000000, ref_select_valid, 1'b0, ref_select,
                    gpio_ref_loss, 1'b0, lock_state_latched, lock_state_live};
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule // rsw_switch_ctrl
`default_nettype wire

// ===== test/rsw_ref_sources.sv
// Model of the four reference sources and the PLL lock monitor.
`timescale 1ns/1ns
`default_nettype none
module rsw_ref_sources (
    input wire logic clock,
    input wire logic [3:0] want,
    input wire logic lose,
    output logic [3:0] ref_valid = 4'h0,
    output logic pll_lock_lost = 1'b0
);
    // Monitors report one edge late, as a real activity detector would.
    always @(posedge clock) begin
        ref_valid <= want;
        pll_lock_lost <= lose;
    end
endmodule // rsw_ref_sources
`default_nettype wire

// ===== test/rsw_switch_ctrl_assertions.sv
// Concurrent checks on the ports of the reference switch control.
`timescale 1ns/1ns
`default_nettype none
module rsw_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [3:0] ref_valid,
    input wire logic pll_lock_lost,
    input wire logic [1:0] ref_select,
    input wire logic ref_select_valid,
    input wire logic lock_state_live,
    input wire logic lock_state_latched,
    input wire logic gpio_ref_loss,
    input wire logic [7:0] holdoff_period
);
    logic [1:0] run_q;
    logic [3:0] valid_q;
    logic lost_q;
    wire acc = psel && penable;
    wire wr_period = acc && pwrite && paddr == 32'h36;
    // Status lags its inputs by one edge, so health is judged on last edge's inputs.
    wire good = ref_select_valid && valid_q[ref_select] && !lost_q;
    // The core leaves reset two edges after the pin, so timed checks wait.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) run_q <= 2'h0;
        else if (run_q != 2'h3) run_q <= run_q + 2'h1;
    end
    // Source and lock inputs as the core saw them at the previous edge.
    always @(posedge clock) begin
        valid_q <= ref_valid;
        lost_q <= pll_lock_lost;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_unmapped_err: assert property (acc && (paddr < 32'h34 || paddr > 32'h38) |-> pslverr)
        else $error("unmapped access without error");
    a_read_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_idle_read_zero: assert property (!acc |-> prdata == 32'h0)
        else $error("read data outside access");
    a_lock_loss_live: assert property (run_q == 2'h3 && pll_lock_lost |=> lock_state_live)
        else $error("lock loss not reported");
    a_live_sets_latch: assert property (lock_state_live |-> lock_state_latched)
        else $error("sticky bit missed a failure");
    a_gpio_needs_live: assert property (gpio_ref_loss |-> lock_state_live)
        else $error("pin shows loss without status");
    a_healthy_clear: assert property (run_q == 2'h3 && good
        |-> !lock_state_live && !gpio_ref_loss)
        else $error("failure shown while healthy");
    a_hold_write_only: assert property (!$stable(holdoff_period)
        |-> $past(wr_period))
        else $error("period changed without write");
endmodule // rsw_chk
bind rsw_switch_ctrl rsw_chk chk (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .ref_valid(ref_valid), .pll_lock_lost(pll_lock_lost), .ref_select(ref_select),
    .ref_select_valid(ref_select_valid), .lock_state_live(lock_state_live),
    .lock_state_latched(lock_state_latched), .gpio_ref_loss(gpio_ref_loss),
    .holdoff_period(holdoff_period));
`default_nettype wire

// ===== test/rsw_switch_ctrl_tb_top.sv
// Self-checking bench for the reference switch control.
`timescale 1ns/1ns
`default_nettype none
module rsw_switch_ctrl_tb_top;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lose = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, pll_lock_lost, rsv, live, latched, gpio;
    logic [3:0] ref_valid, want = 4'h0;
    logic [2:0] x;
    logic [1:0] ref_select, hs, ha;
    logic [7:0] hp, rk;
    logic [7:0] wv [4];
    int n_mismatch = 0, n_tests = 0, cyc = 0, i, p;
    always #5 clock = ~clock;
    // A hang is cut short well past the expected run length.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            results();
        end
    end
    rsw_ref_sources src (.clock(clock), .want(want), .lose(lose), .ref_valid(ref_valid),
        .pll_lock_lost(pll_lock_lost));
    rsw_switch_ctrl uut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ref_valid(ref_valid), .pll_lock_lost(pll_lock_lost),
        .ref_select(ref_select), .ref_select_valid(rsv), .lock_state_live(live),
        .lock_state_latched(latched), .gpio_ref_loss(gpio), .holdoff_period(hp),
        .holdoff_prescale(hs), .holdoff_aux_field(ha));
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] v);
        n_tests++;
        if (s !== v) begin
            n_mismatch++;
            $display("FAIL %s exp %h seen %h", n, v, s);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the bench timeout may end this wait.
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] v, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, r, v);
    endtask
    // New source pattern, then time for monitor, pick and output stages.
    task automatic setv(input logic [3:0] v);
        @(posedge clock);
        want <= v;
        repeat (6) @(posedge clock);
    endtask
    // Best valid input: highest nonzero rank, lowest index on ties.
    function automatic logic [2:0] pick(input logic [7:0] k, input logic [3:0] v);
        logic [1:0] b;
        b = 2'h0;
        pick = 3'h0;
        for (int j = 0; j < 4; j++)
            if (v[j] && k[7-2*j -: 2] > b) begin
                b = k[7-2*j -: 2];
                pick = {1'b1, j[1:0]};
            end
    endfunction
    initial begin
        void'($urandom(33127));
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        rdc(8'h34, 32'he4, "ranks");
        rdc(8'h35, 32'h0, "ctl");
        rdc(8'h36, 32'h80, "period");
        rdc(8'h37, 32'h0, "hdc");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {31'h0, e}, 32'h1);
        // Walk the four configuration bytes; the status word, where a write only clears the sticky bit, is left out.
        for (i = 0; i < 8; i++) begin
            p = $urandom;
            wv[i[1:0]] = p[7:0];
            rk = i[1:0] == 2'h1 ? 8'h6f : i[1:0] == 2'h3 ? 8'hc3 : 8'hff;
            apb(1'b1, 8'h34 + i[1:0], p);
            rdc(8'h34 + i[1:0], p & rk, "rw");
        end
        chk("outs", {hp, hs, ha}, {wv[2], wv[3][7:6], wv[3][1:0]});
        setv(4'hf);
        for (p = 0; p < 8; p++) begin
            apb(1'b1, 8'h35, 8'h20 | (p[2] ? 8'h08 : 8'h00) | p[1:0]);
            setv(4'h7 ^ p[3:0]);
            setv(4'hf);
            chk("manual", {rsv, ref_select}, {1'b1, p[1:0]});
        end
        for (i = 0; i < 24; i++) begin
            rk = $urandom;
            p = $urandom;
            apb(1'b1, 8'h35, i[0] ? 8'h0c : 8'h04);
            apb(1'b1, 8'h34, rk);
            setv(4'h0);
            setv(p[3:0]);
            x = pick(rk, p[3:0]);
            chk("found", rsv, x[2]);
            if (x[2]) chk("auto", ref_select, x[1:0]);
        end
        apb(1'b1, 8'h34, 8'he4);
        for (i = 0; i < 2; i++) begin
            apb(1'b1, 8'h35, i[0] ? 8'h24 : 8'h04);
            setv(4'h0);
            setv(4'h6);
            setv(4'he);
            chk("low rank", ref_select, 2'h1);
            setv(4'hf);
            chk("revert", ref_select, i[0] ? 2'h0 : 2'h1);
        end
        for (i = 0; i < 2; i++) begin
            apb(1'b1, 8'h35, i[0] ? 8'h40 : 8'h00);
            setv(4'hf);
            apb(1'b1, 8'h38, 32'h2);
            setv(4'he);
            chk("refloss", {live, latched, gpio}, i[0] ? 3'h0 : 3'h7);
            rdc(8'h38, i[0] ? 32'h80 : 32'h8b, "status");
            lose <= 1'b1;
            repeat (4) @(posedge clock);
            chk("lockloss", {live, latched, gpio}, {2'h3, ~i[0]});
            lose <= 1'b0;
        end
        setv(4'hf);
        apb(1'b1, 8'h38, 32'h2);
        repeat (3) @(posedge clock);
        chk("clear", {live, latched}, 2'h0);
        results();
    end
endmodule // rsw_switch_ctrl_tb_top
`default_nettype wire
